// [rdp_cfg.svh]
// Constants of the RAM disk host port: offsets, field positions, reset values, sizes.
// Assumes inclusion by bare name from every file that needs a constant.
// Function
// R01 - Claim host I/O with io_request, A7 high, A1-A6 low
// R02 - Address bit zero picks select; needs upper match
// R03 - Odd address read gives status read strobe
// R04 - Odd address write is command write
// R05 - Even address read gives data read strobe
// R06 - Even address write is data write
// R07 - Two 8-bit buffers, one per direction
// R08 - Buffers capture on rising latch strobe
// R09 - Buffers drive bus only while out_drive_n low
// R10 - Input buffer latches host odd-address writes; code also passes even-address writes, tagged by kind
// R11 - Local port 03 read returns input buffer
// R12 - Handshake set on port 03 read, cleared reset/01
// R13 - Local port 01 read gives jumper, protect switch
// R14 - Local port 03 read returns held byte
// R15 - Port 00 write loads output, sets waiting flag
// R16 - Boot ROM plus banked DRAM beyond 64 KB
// R17 - Reset clears both bank latch outputs low
// R18 - Power-on mapping: high bank 1, pair 0
// R19 - NAND upper-zero detect with high bank select
// R20 - After reset address 0000 hits boot ROM
// R21 - Bank latch written via local ports 02, 03
// R22 - Top 64 bytes always map to common DRAM
`ifndef RDP_CFG_SVH
`define RDP_CFG_SVH
// Host I/O offsets
`define RDP_HOST_DATA_PORT 8'h80
`define RDP_HOST_CMD_STATUS_PORT 8'h81
// Local I/O ports
`define RDP_LOCAL_OUT_PORT 8'h00
`define RDP_LOCAL_SWITCH_PORT 8'h01
`define RDP_LOCAL_BANK_PAIR_PORT 8'h02
`define RDP_LOCAL_INPUT_PORT 8'h03
// Status byte bit positions
`define RDP_STAT_OUT_FULL_BIT 0
`define RDP_STAT_BUSY_BIT 1
`define RDP_STAT_IN_FULL_BIT 2
// Switch byte bit positions
`define RDP_SW_JUMPER_BIT 0
`define RDP_SW_PROTECT_BIT 1
`define RDP_SW_CMD_TAG_BIT 2
// Reset values
`define RDP_BYTE_RESET 8'h00
`define RDP_BANK_RESET 1'b0
// FIFO shape: tag bit plus byte, eight entries
`define RDP_FIFO_WIDTH 9
`define RDP_FIFO_DEPTH 8
// Common area: address bits 15..6 all ones
`define RDP_COMMON_MASK 10'h3ff
`endif

// [rdp_fifo.sv]
// Flip-flop FIFO holding host bytes for the local processor.
// Assumes one clock; full and empty are exact; the host port ignores push_ready, so a push while full is dropped.
`timescale 1ns/1ps
`default_nettype none
`include "rdp_cfg.svh"
module rdp_fifo #(
	parameter int WIDTH = `RDP_FIFO_WIDTH,
	parameter int DEPTH = `RDP_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	rdp_fifo_if.store port
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH]; // Storage, indexed by pointer
	logic [AW-1:0] wr_ptr_reg; // Next slot to write
	logic [AW-1:0] rd_ptr_reg; // Head slot
	logic [AW:0] count_reg; // Entries held
	wire push_go = port.push_valid && port.push_ready; // Accepted push
	wire pop_go = port.pop_ready && port.pop_valid; // Accepted pop
	assign port.push_ready = (count_reg != DEPTH[AW:0]);
	assign port.pop_valid = (count_reg != '0);
	assign port.pop_data = mem_reg[rd_ptr_reg];
	// Storage write; no reset needed since count gates reads
	always_ff @(posedge clk) begin
		if (push_go) begin
			mem_reg[wr_ptr_reg] <= port.push_data;
		end
	end
	// Pointers and occupancy; wrap works because depth is a power of two
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push_go) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop_go) rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + {{AW{1'b0}}, push_go} - {{AW{1'b0}}, pop_go};
		end
	end
endmodule : rdp_fifo
`default_nettype wire

// [rdp_fifo_if.sv]
// Carrier between the host port and its input FIFO.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface rdp_fifo_if;
	logic push_valid; // Entry offered
	logic push_ready; // Room for it
	rdp_pkg::rdp_entry_type push_data; // Entry pushed
	logic pop_valid; // Head present
	logic pop_ready; // Head taken
	rdp_pkg::rdp_entry_type pop_data; // Head entry
	modport user (output push_valid, output push_data, input push_ready,
		input pop_valid, input pop_data, output pop_ready);
	modport store (input push_valid, input push_data, output push_ready,
		output pop_valid, output pop_data, input pop_ready);
endinterface : rdp_fifo_if
`default_nettype wire

// [rdp_host_model.sv]
// Host processor bus model that drives the port's host pins.
// Assumes clk is the port clock; pins change only on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module rdp_host_model (
	input wire logic clk,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe,
	output logic [7:0] host_addr,
	output logic host_io_request_n,
	output logic host_rd_n,
	output logic host_wr_n,
	output logic [7:0] host_data_in
);
	// Idle bus from time zero
	initial begin
		host_addr = 8'h00;
		host_io_request_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		host_data_in = 8'h00;
	end
	// Drop the strobe, hold address three clocks, then scramble it
	task automatic release_bus(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		host_io_request_n = 1'b1;
		host_rd_n = 1'b1;
		host_wr_n = 1'b1;
		repeat (3) @(negedge clk);
		host_addr = ~a; // Stale values must not look valid
		host_data_in = ~d;
		repeat (2) @(negedge clk);
	endtask : release_bus
	// Write cycle, strobe low for four clocks
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		host_addr = a;
		host_data_in = d;
		host_io_request_n = 1'b0;
		host_wr_n = 1'b0;
		repeat (3) @(negedge clk);
		release_bus(a, d);
	endtask : wr
	// Read cycle, strobe held until the port drives the bus
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		d = 8'hxx;
		@(negedge clk);
		host_addr = a;
		host_io_request_n = 1'b0;
		host_rd_n = 1'b0;
		// Look at the settled outputs on the falling edge, never at the launching edge
		for (int i = 0; i < 8 && host_data_oe !== 1'b1; i++) @(negedge clk);
		d = (host_data_oe === 1'b1) ? host_data_out : 8'hxx; // Undriven bus must not pass
		release_bus(a, ~host_data_in);
	endtask : rd
endmodule : rdp_host_model
`default_nettype wire

// [rdp_pkg.sv]
// Types shared by the RAM disk host port modules.
// Assumes rdp_cfg.svh sits in the same folder.
`include "rdp_cfg.svh"
package rdp_pkg;
	typedef logic [7:0] rdp_byte_type; // One bus byte
	typedef struct packed {
		logic cmd; // High when the byte came in as a command
		rdp_byte_type data; // Byte itself
	} rdp_entry_type;
endpackage : rdp_pkg

// [rdp_port.sv]
// Host port of the RAM disk unit: host I/O decode, buffers, handshake, bank control.
// Assumes host pins are asynchronous to clk; local processor bus is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "rdp_cfg.svh"
module rdp_port (
	input wire logic clk,
	input wire logic rstn,
	// Host processor bus pins
	input wire logic host_reset_n,
	input wire logic [7:0] host_addr,
	input wire logic host_io_request_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	// Decoder selects and strobes
	output logic host_sel_even,
	output logic host_sel_odd,
	output logic status_read,
	output logic command_write,
	output logic data_read,
	output logic data_write,
	output logic host_input_ready,
	// Local processor bus
	input wire logic [15:0] local_addr,
	input wire logic local_io_request_n,
	input wire logic local_mreq_n,
	input wire logic local_rd_n,
	input wire logic local_wr_n,
	input wire logic [7:0] local_data_in,
	output logic [7:0] local_data_out,
	output logic local_data_oe,
	// Straps
	input wire logic capacity_jumper,
	input wire logic write_protect_switch,
	// Memory mapping
	output logic boot_rom_select,
	output logic dram_select,
	output logic dram_bank_high,
	output logic bank_pair_select,
	output logic high_bank_select
);
	// Synchroniser for all asynchronous pins
	localparam int SW = 22;
	logic [SW-1:0] sync1_reg; // First stage, read only by second stage
	logic [SW-1:0] sync2_reg; // Second stage, safe to use
	wire [SW-1:0] pins = {host_reset_n, host_addr, host_io_request_n, host_rd_n,
		host_wr_n, host_data_in, capacity_jumper, write_protect_switch};
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg <= {SW{1'b1}};
			sync2_reg <= {SW{1'b1}};
		end else begin
			sync1_reg <= pins;
			sync2_reg <= sync1_reg;
		end
	end
	// Named fields of the synchronised pins
	wire hs_reset_n = sync2_reg[21];
	wire [7:0] hs_addr = sync2_reg[20:13];
	wire hs_io_request_n = sync2_reg[12];
	wire hs_rd_n = sync2_reg[11];
	wire hs_wr_n = sync2_reg[10];
	wire [7:0] hs_data = sync2_reg[9:2];
	wire hs_jumper = sync2_reg[1];
	wire hs_protect = sync2_reg[0];

	// Host address decode: only 80h and 81h are claimed
	wire upper_match = !hs_io_request_n && hs_addr[7] && (hs_addr[6:1] == 6'h00); // R01
	wire sel_even_next = upper_match && !hs_addr[0]; // R02
	wire sel_odd_next = upper_match && hs_addr[0]; // R02
	// Strobe decode from the select and the read/write lines
	wire stat_rd_next = sel_odd_next && !hs_rd_n; // R03
	wire cmd_wr_next = sel_odd_next && !hs_wr_n; // R04
	wire dat_rd_next = sel_even_next && !hs_rd_n; // R05
	wire dat_wr_next = sel_even_next && !hs_wr_n; // R06

	// Registered decode outputs; previous values also mark strobe ends
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_sel_even <= 1'b0;
			host_sel_odd <= 1'b0;
			status_read <= 1'b0;
			command_write <= 1'b0;
			data_read <= 1'b0;
			data_write <= 1'b0;
		end else begin
			host_sel_even <= sel_even_next;
			host_sel_odd <= sel_odd_next;
			status_read <= stat_rd_next;
			command_write <= cmd_wr_next;
			data_read <= dat_rd_next;
			data_write <= dat_wr_next;
		end
	end
	// Write strobe end acts as the latch strobe rising edge
	wire cmd_wr_end = command_write && !cmd_wr_next; // R08
	wire dat_wr_end = data_write && !dat_wr_next; // R08
	// Data read end empties the output buffer
	wire dat_rd_end = data_read && !dat_rd_next;
	// Data captured one cycle before the strobe ended, still valid on the bus
	logic [7:0] host_data_hold_reg; // Host byte seen while strobe active
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) host_data_hold_reg <= `RDP_BYTE_RESET;
		else host_data_hold_reg <= hs_data;
	end

	// Host reset from the pin, synchronised
	wire host_reset = !hs_reset_n;

	// Input FIFO in the host-to-local path
	rdp_fifo_if fifo_bus ();
	rdp_fifo #(
		.WIDTH(`RDP_FIFO_WIDTH),
		.DEPTH(`RDP_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rstn(rstn),
		.port(fifo_bus)
	);
	// Both host write kinds enter the input path, tagged by kind
	assign fifo_bus.push_valid = cmd_wr_end || dat_wr_end; // R10
	// One driver for the whole entry: tag bit on top, byte below
	assign fifo_bus.push_data = {cmd_wr_end, host_data_hold_reg}; // R04 R06

	// Local I/O decode; strobes are levels, actions fire on the leading edge
	wire local_io_rd = !local_io_request_n && !local_rd_n;
	wire local_io_wr = !local_io_request_n && !local_wr_n;
	wire [7:0] lport = local_addr[7:0];
	wire rd_sw_lvl = local_io_rd && (lport == `RDP_LOCAL_SWITCH_PORT);
	wire rd_in_lvl = local_io_rd && (lport == `RDP_LOCAL_INPUT_PORT);
	wire wr_out_lvl = local_io_wr && (lport == `RDP_LOCAL_OUT_PORT);
	wire wr_sw_lvl = local_io_wr && (lport == `RDP_LOCAL_SWITCH_PORT);
	wire wr_pair_lvl = local_io_wr && (lport == `RDP_LOCAL_BANK_PAIR_PORT);
	wire wr_high_lvl = local_io_wr && (lport == `RDP_LOCAL_INPUT_PORT);
	logic local_rd_prev_reg; // Previous local I/O read level
	logic local_wr_prev_reg; // Previous local I/O write level
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			local_rd_prev_reg <= 1'b0;
			local_wr_prev_reg <= 1'b0;
		end else begin
			local_rd_prev_reg <= local_io_rd;
			local_wr_prev_reg <= local_io_wr;
		end
	end
	wire rd_start = local_io_rd && !local_rd_prev_reg;
	wire wr_start = local_io_wr && !local_wr_prev_reg;
	wire rd_in_go = rd_in_lvl && rd_start;
	wire wr_out_go = wr_out_lvl && wr_start;
	wire wr_sw_go = wr_sw_lvl && wr_start;
	wire wr_pair_go = wr_pair_lvl && wr_start;
	wire wr_high_go = wr_high_lvl && wr_start;
	// Port 03 read takes the FIFO head into the input buffer
	assign fifo_bus.pop_ready = rd_in_go; // R11

	// Input buffer: last byte handed to the local processor
	logic [7:0] in_buf_reg; // R07
	logic in_cmd_reg; // Kind of that byte
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			in_buf_reg <= `RDP_BYTE_RESET;
			in_cmd_reg <= 1'b0;
		end else if (rd_in_go && fifo_bus.pop_valid) begin
			in_buf_reg <= fifo_bus.pop_data.data; // R14
			in_cmd_reg <= fifo_bus.pop_data.cmd;
		end
	end

	// Output buffer and its waiting flag
	logic [7:0] out_buf_reg; // R07
	logic out_full_reg; // Byte waiting for the host
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) out_buf_reg <= `RDP_BYTE_RESET;
		else if (wr_out_go) out_buf_reg <= local_data_in; // R15
	end
	// Set wins over the host's read so a new byte is never lost
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) out_full_reg <= 1'b0;
		else if (wr_out_go) out_full_reg <= 1'b1; // R15
		else if (dat_rd_end || host_reset) out_full_reg <= 1'b0;
	end

	// Handshake flip-flop: busy while the local side works on a byte
	logic busy_reg;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) busy_reg <= 1'b0;
		else if (rd_in_go) busy_reg <= 1'b1; // R12
		else if (host_reset || wr_sw_go) busy_reg <= 1'b0; // R12
	end

	// Status byte seen by the host
	wire [7:0] status_byte = (8'h01 << `RDP_STAT_OUT_FULL_BIT) & {8{out_full_reg}}
		| (8'h01 << `RDP_STAT_BUSY_BIT) & {8{busy_reg}}
		| (8'h01 << `RDP_STAT_IN_FULL_BIT) & {8{!fifo_bus.push_ready}};

	// Host bus drive: only during a claimed read, high impedance otherwise
	wire host_drive_n = !(stat_rd_next || dat_rd_next); // R09
	wire [7:0] host_out_next = stat_rd_next ? status_byte : out_buf_reg; // R03 R05
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			host_data_out <= `RDP_BYTE_RESET;
			host_data_oe <= 1'b0;
		end else begin
			host_data_out <= host_drive_n ? `RDP_BYTE_RESET : host_out_next;
			host_data_oe <= !host_drive_n; // R09
		end
	end
	// Room flag for the host; software polls it before writing
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) host_input_ready <= 1'b0;
		else host_input_ready <= fifo_bus.push_ready;
	end

	// Switch byte for local port 01
	wire [7:0] switch_byte = (8'h01 << `RDP_SW_JUMPER_BIT) & {8{hs_jumper}}
		| (8'h01 << `RDP_SW_PROTECT_BIT) & {8{hs_protect}}
		| (8'h01 << `RDP_SW_CMD_TAG_BIT) & {8{in_cmd_reg}}; // R13
	// Local bus drive; port 03 returns the FIFO head during the popping read
	wire local_drive_n = !(rd_sw_lvl || rd_in_lvl); // R09
	wire [7:0] in_view = (rd_in_go && fifo_bus.pop_valid) ? fifo_bus.pop_data.data
		: in_buf_reg; // R11
	wire [7:0] local_out_next = rd_sw_lvl ? switch_byte : in_view; // R13 R14
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			local_data_out <= `RDP_BYTE_RESET;
			local_data_oe <= 1'b0;
		end else begin
			local_data_out <= local_drive_n ? local_data_out : local_out_next;
			local_data_oe <= !local_drive_n; // R09
		end
	end

	// Bank latch; reset leaves both outputs low, the boot mapping
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bank_pair_select <= `RDP_BANK_RESET; // R17
			high_bank_select <= `RDP_BANK_RESET; // R17
		end else if (host_reset) begin
			bank_pair_select <= `RDP_BANK_RESET; // R18
			high_bank_select <= `RDP_BANK_RESET; // R18
		end else begin
			if (wr_pair_go) bank_pair_select <= local_data_in[0]; // R21
			if (wr_high_go) high_bank_select <= local_data_in[0]; // R21
		end
	end

	// Memory decode of the local address
	wire upper_zero = (local_addr[15:12] == 4'h0); // R19
	wire rom_term = !(upper_zero && high_bank_select); // R19
	wire rom_next = !local_mreq_n && upper_zero && rom_term; // R20
	wire common_hit = (local_addr[15:6] == `RDP_COMMON_MASK); // R22
	// Low latch state maps the high bank; the ROM shadows its first 4 KB
	wire bank_next = common_hit || !high_bank_select || bank_pair_select; // R16 R22
	// Registered so every output comes from a flip-flop; adds one cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_rom_select <= 1'b0;
			dram_select <= 1'b0;
			dram_bank_high <= 1'b0;
		end else begin
			boot_rom_select <= rom_next; // R20
			dram_select <= !local_mreq_n && !rom_next; // R16
			dram_bank_high <= bank_next; // R16
		end
	end
endmodule : rdp_port
`default_nettype wire

// [rdp_port_sva.sv]
// Checker on the host port's pins.
// Assumes host pins are idle during reset; decode lags the pins by three clocks.
`timescale 1ns/1ps
`default_nettype none
module rdp_port_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic host_reset_n,
	input wire logic [7:0] host_addr,
	input wire logic host_io_request_n,
	input wire logic host_rd_n,
	input wire logic host_wr_n,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic host_sel_even,
	input wire logic host_sel_odd,
	input wire logic status_read,
	input wire logic command_write,
	input wire logic data_read,
	input wire logic data_write,
	input wire logic [15:0] local_addr,
	input wire logic local_io_request_n,
	input wire logic local_mreq_n,
	input wire logic local_rd_n,
	input wire logic local_data_oe,
	input wire logic dram_select,
	input wire logic dram_bank_high,
	input wire logic boot_rom_select,
	input wire logic bank_pair_select,
	input wire logic high_bank_select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	// Claimed host cycle seen through the synchroniser
	sequence host_at(logic [7:0] a);
		!$past(host_io_request_n, 3) && $past(host_addr, 3) == a;
	endsequence
	// Local read of one I/O port
	sequence local_rd_at(logic [7:0] p);
		!local_io_request_n && !local_rd_n && local_addr[7:0] == p;
	endsequence
	even_sel_a: assert property (host_sel_even |-> host_at(8'h80))
		else $error("even select without its address");
	odd_sel_a: assert property (host_sel_odd |-> !host_sel_even ##0 host_at(8'h81))
		else $error("odd select without its address");
	status_drive_a: assert property (status_read |-> host_data_oe && host_data_out[7:3] == 5'h00)
		else $error("status read not driven");
	cmd_write_a: assert property (command_write |-> !$past(host_wr_n, 3) ##0 host_at(8'h81))
		else $error("command write without odd write");
	data_read_a: assert property (data_read |-> host_data_oe ##0 host_at(8'h80))
		else $error("data read not driven");
	data_write_a: assert property (data_write |-> !$past(host_wr_n, 3) ##0 host_at(8'h80))
		else $error("data write without even write");
	bus_quiet_a: assert property (!host_data_oe |-> host_data_out == 8'h00)
		else $error("host bus data while not driving");
	local_read_a: assert property ((local_rd_at(8'h01) or local_rd_at(8'h03)) |=> local_data_oe)
		else $error("local read not driven");
	rom_map_a: assert property (!local_mreq_n && local_addr[15:12] == 4'h0 && !high_bank_select
		|=> boot_rom_select && !dram_select)
		else $error("boot ROM not selected");
	common_area_a: assert property (!local_mreq_n && local_addr[15:6] == 10'h3ff
		|=> dram_bank_high && dram_select)
		else $error("top area not common");
	bank_reset_a: assert property (!host_reset_n [*4] |-> !high_bank_select && !bank_pair_select)
		else $error("bank latch survives host reset");
endmodule : rdp_port_sva
bind rdp_port rdp_port_sva rdp_port_sva_i (.clk(clk), .rstn(rstn), .host_reset_n(host_reset_n),
	.host_addr(host_addr), .host_io_request_n(host_io_request_n), .host_rd_n(host_rd_n),
	.host_wr_n(host_wr_n), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
	.host_sel_even(host_sel_even), .host_sel_odd(host_sel_odd), .status_read(status_read),
	.command_write(command_write), .data_read(data_read), .data_write(data_write),
	.local_addr(local_addr), .local_io_request_n(local_io_request_n),
	.local_mreq_n(local_mreq_n), .local_rd_n(local_rd_n), .local_data_oe(local_data_oe),
	.dram_select(dram_select), .dram_bank_high(dram_bank_high),
	.boot_rom_select(boot_rom_select), .bank_pair_select(bank_pair_select),
	.high_bank_select(high_bank_select));
`default_nettype wire

// [tb.sv]
// Bench for the RAM disk host port: host model on one side, local bus tasks here.
// Assumes the port, its FIFO and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, rstn, host_reset_n, host_io_request_n, host_rd_n, host_wr_n, host_data_oe;
	logic host_sel_even, host_sel_odd, status_read, command_write, data_read, data_write;
	logic host_input_ready, local_io_request_n, local_mreq_n, local_rd_n, local_wr_n;
	logic local_data_oe, capacity_jumper, write_protect_switch, boot_rom_select, dram_select;
	logic dram_bank_high, bank_pair_select, high_bank_select;
	logic [7:0] host_addr, host_data_in, host_data_out, local_data_in, local_data_out, d;
	logic [15:0] local_addr;
	int errors, tests_run;
	rdp_port rdp_port_i (.clk(clk), .rstn(rstn), .host_reset_n(host_reset_n),
		.host_addr(host_addr), .host_io_request_n(host_io_request_n), .host_rd_n(host_rd_n),
		.host_wr_n(host_wr_n), .host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .host_sel_even(host_sel_even), .host_sel_odd(host_sel_odd),
		.status_read(status_read), .command_write(command_write), .data_read(data_read),
		.data_write(data_write), .host_input_ready(host_input_ready), .local_addr(local_addr),
		.local_io_request_n(local_io_request_n), .local_mreq_n(local_mreq_n),
		.local_rd_n(local_rd_n), .local_wr_n(local_wr_n), .local_data_in(local_data_in),
		.local_data_out(local_data_out), .local_data_oe(local_data_oe),
		.capacity_jumper(capacity_jumper), .write_protect_switch(write_protect_switch),
		.boot_rom_select(boot_rom_select), .dram_select(dram_select),
		.dram_bank_high(dram_bank_high), .bank_pair_select(bank_pair_select),
		.high_bank_select(high_bank_select));
	rdp_host_model rdp_host_model_i (.clk(clk), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .host_addr(host_addr),
		.host_io_request_n(host_io_request_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
		.host_data_in(host_data_in));
	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Byte compare, counted
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Local I/O write, one clock edge inside the strobe
	task automatic lwr(input logic [7:0] p, input logic [7:0] v);
		@(negedge clk);
		local_addr = {8'h00, p};
		local_data_in = v;
		local_io_request_n = 1'b0;
		local_wr_n = 1'b0;
		@(negedge clk);
		local_io_request_n = 1'b1;
		local_wr_n = 1'b1;
		local_data_in = ~v; // Released data is scrambled
		@(negedge clk);
	endtask : lwr
	// Local I/O read, data taken on the falling edge after the first rising edge
	task automatic lrd(input logic [7:0] p, output logic [7:0] v);
		@(negedge clk);
		local_addr = {8'h00, p};
		local_io_request_n = 1'b0;
		local_rd_n = 1'b0;
		@(negedge clk);
		v = local_data_out;
		chk("local_oe", 8'h01, {7'h00, local_data_oe});
		@(negedge clk);
		local_io_request_n = 1'b1;
		local_rd_n = 1'b1;
		@(negedge clk);
	endtask : lrd
	// Memory access; returns rom, dram, bank-high one clock later
	task automatic mem(input logic [15:0] a, output logic [7:0] v);
		@(negedge clk);
		local_addr = a;
		local_mreq_n = 1'b0;
		@(negedge clk);
		v = {5'h00, boot_rom_select, dram_select, dram_bank_high};
		local_mreq_n = 1'b1;
	endtask : mem
	// Reset state and power-on mapping
	task automatic t_reset;
		chk("bank_latch", 8'h00, {6'h00, high_bank_select, bank_pair_select});
		mem(16'h0000, d);
		chk("map_0000", 8'h05, d);
		rdp_host_model_i.rd(8'h81, d);
		chk("status", 8'h00, d);
		$display("test reset done");
	endtask : t_reset
	// Host bytes reach the local side in order, with handshake
	task automatic t_host_in;
		rdp_host_model_i.wr(8'h81, 8'ha5);
		rdp_host_model_i.wr(8'h80, 8'h3c);
		rdp_host_model_i.wr(8'h82, 8'hff);
		lrd(8'h03, d);
		chk("in_cmd", 8'ha5, d);
		lrd(8'h01, d);
		chk("switch_cmd", 8'h05, d);
		rdp_host_model_i.rd(8'h81, d);
		chk("status_busy", 8'h02, d);
		capacity_jumper = 1'b0;
		write_protect_switch = 1'b1;
		lrd(8'h03, d);
		chk("in_data", 8'h3c, d);
		lrd(8'h01, d);
		chk("switch_data", 8'h02, d);
		lwr(8'h01, 8'h00);
		rdp_host_model_i.rd(8'h81, d);
		chk("status_clear", 8'h00, d);
		lrd(8'h03, d);
		chk("in_empty", 8'h3c, d);
		lwr(8'h01, 8'h00);
		$display("test host_in done");
	endtask : t_host_in
	// Local byte to host through the output buffer
	task automatic t_host_out;
		lwr(8'h00, 8'h96);
		rdp_host_model_i.rd(8'h81, d);
		chk("status_out", 8'h01, d);
		rdp_host_model_i.rd(8'h80, d);
		chk("out_data", 8'h96, d);
		rdp_host_model_i.rd(8'h81, d);
		chk("status_taken", 8'h00, d);
		$display("test host_out done");
	endtask : t_host_out
	// Fill the FIFO past full while the local side stalls, then drain it
	task automatic t_fifo;
		for (int i = 0; i < 9; i++) rdp_host_model_i.wr(8'h80, 8'h10 + 8'(i));
		chk("ready_full", 8'h00, {7'h00, host_input_ready});
		rdp_host_model_i.rd(8'h81, d);
		chk("status_full", 8'h04, d);
		for (int i = 0; i < 8; i++) begin
			lrd(8'h03, d);
			chk("drain", 8'h10 + 8'(i), d);
		end
		chk("ready_empty", 8'h01, {7'h00, host_input_ready});
		lwr(8'h01, 8'h00);
		$display("test fifo done");
	endtask : t_fifo
	// Bank latch writes, mapping, host reset
	task automatic t_bank;
		lwr(8'h02, 8'h01);
		lwr(8'h03, 8'h01);
		chk("bank_set", 8'h03, {6'h00, high_bank_select, bank_pair_select});
		mem(16'h0000, d);
		chk("map_banked", 8'h03, d);
		lwr(8'h02, 8'h00);
		mem(16'h0000, d);
		chk("map_low", 8'h02, d);
		mem(16'hffc0, d);
		chk("map_common", 8'h03, d);
		host_reset_n = 1'b0;
		repeat (4) @(negedge clk);
		host_reset_n = 1'b1;
		repeat (3) @(negedge clk);
		chk("bank_reset", 8'h00, {6'h00, high_bank_select, bank_pair_select});
		mem(16'h0000, d);
		chk("map_boot", 8'h05, d);
		$display("test bank done");
	endtask : t_bank
	// Counts and verdict
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : results
	// Main sequence
	initial begin
		{rstn, local_wr_n, local_mreq_n, local_rd_n, local_io_request_n} = 5'h0f;
		host_reset_n = 1'b1;
		local_addr = 16'h0000;
		local_data_in = 8'h00;
		capacity_jumper = 1'b1;
		write_protect_switch = 1'b0;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_host_in();
		t_host_out();
		t_fifo();
		t_bank();
		results();
	end
	// Run takes about 300 clocks; cut off well beyond that
	initial begin
		#100000;
		errors++;
		results();
	end
endmodule : tb
`default_nettype wire
